// ===== logic/tcim_cfg.svh
/*
 Offsets, field positions, reset values and widths of the timer channel
 interrupt mask block. Assumes inclusion by bare name from logic files.
*/
`ifndef TCIM_CFG_SVH
`define TCIM_CFG_SVH

`define TCIM_OFS_ENABLE 4'h0
`define TCIM_OFS_DISABLE 4'h4
`define TCIM_OFS_MASK 4'h8
`define TCIM_OFS_STATUS 4'hc
`define TCIM_OFS_MODE 4'h0
`define TCIM_ADDR_W 4

`define TCIM_BIT_OVF 0
`define TCIM_BIT_LOVR 1
`define TCIM_BIT_CMPA 2
`define TCIM_BIT_CMPB 3
`define TCIM_BIT_CMPC 4
`define TCIM_BIT_LDA 5
`define TCIM_BIT_LDB 6
`define TCIM_BIT_ETRG 7
`define TCIM_NSRC 8

`define TCIM_MASK_RST 8'h00
`define TCIM_FLAG_RST 8'h00
`define TCIM_RESP_OKAY 2'h0
`define TCIM_RESP_SLVERR 2'h2

`endif

// ===== logic/tcim_pkg.sv
/*
 Types shared by the timer channel interrupt mask block.
 Assumes the constants header is included where offsets are needed.
*/
package tcim_pkg;
    typedef logic [7:0] tcim_src_t;
    typedef enum logic [1:0]
    {
        TCIM_W_IDLE = 2'b00,
        TCIM_W_RESP = 2'b01
    } tcim_wstate_e;
endpackage

// ===== logic/tcim_flag_bit.sv
/*
 One sticky event flag: set by a hardware event, cleared by a status read.
 Assumes event and clear are synchronous single-cycle pulses.
*/
`timescale 1ns/1ps
module tcim_flag_bit
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic setPulse,
    input wire logic clrPulse,
    output logic flag_q
);
    logic flag_d;

    always_comb
    begin
        // Set beats clear so no event is lost
        flag_d = setPulse | (flag_q & ~clrPulse);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    a_flag_set_wins: assert property (@(posedge clk_sys)
        disable iff (!resetn) setPulse |=> flag_q)
        else $error("flag lost event");
endmodule

// ===== logic/tcim_mask_bit.sv
/*
 One interrupt mask bit with write-one-to-set and write-one-to-clear.
 Assumes the write strobes are single-cycle pulses from the bus slave.
*/
`timescale 1ns/1ps
module tcim_mask_bit
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enPulse,
    input wire logic disPulse,
    output logic mask_q
);
    logic mask_d;

    always_comb
    begin
        // Enable wins if software hits both in one cycle
        mask_d = enPulse | (mask_q & ~disPulse);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            mask_q <= 1'b0;
        else
            mask_q <= mask_d;
    end
endmodule

// ===== logic/tcim_top.sv
/*
 Timer channel interrupt mask: eight sticky source flags, an enable and a
 disable register that set and clear mask bits, a readable mask, a
 clear-on-read status and the channel interrupt, behind AXI4-Lite.
 Assumes event inputs are synchronous one-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
`include "tcim_cfg.svh"

module tcim_top
    import tcim_pkg::*;
#(
    parameter int NSRC = `TCIM_NSRC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic waveMode,
    input wire logic evtOverflow,
    input wire logic evtLoadOverrun,
    input wire logic evtCompareA,
    input wire logic evtCompareB,
    input wire logic evtCompareC,
    input wire logic evtCaptureA,
    input wire logic evtCaptureB,
    input wire logic evtExtTrigger,
    input wire logic [`TCIM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`TCIM_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic chanIrq_q
);
    tcim_src_t events;
    tcim_src_t maskBits;
    tcim_src_t flagBits;
    tcim_src_t enStrobe;
    tcim_src_t disStrobe;
    logic statusRead;

    // Write channel state
    logic awHeld_q, awHeld_d;
    logic wHeld_q, wHeld_d;
    logic [`TCIM_ADDR_W-1:0] awAddr_q, awAddr_d;
    logic [7:0] wData_q, wData_d;
    logic wLane0_q, wLane0_d;
    logic bValid_q, bValid_d;
    logic [1:0] bResp_q, bResp_d;
    logic doWrite;

    // Read channel state
    logic rValid_q, rValid_d;
    logic [31:0] rData_q, rData_d;
    logic [1:0] rResp_q, rResp_d;
    logic arTake;
    logic irq_d;

    assign events[`TCIM_BIT_OVF] = evtOverflow;
    assign events[`TCIM_BIT_LOVR] = evtLoadOverrun;
    assign events[`TCIM_BIT_CMPA] = evtCompareA;
    assign events[`TCIM_BIT_CMPB] = evtCompareB;
    assign events[`TCIM_BIT_CMPC] = evtCompareC;
    assign events[`TCIM_BIT_LDA] = evtCaptureA;
    assign events[`TCIM_BIT_LDB] = evtCaptureB;
    assign events[`TCIM_BIT_ETRG] = evtExtTrigger;

    // Address and data are taken independently, in either order
    always_comb
    begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wLane0_d = wLane0_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        doWrite = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata[7:0];
            wLane0_d = s_axi_wstrb[0];
        end
        if (awHeld_q && wHeld_q && !bValid_q)
        begin
            doWrite = 1'b1;
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = (awAddr_q == `TCIM_OFS_ENABLE ||
                awAddr_q == `TCIM_OFS_DISABLE) ? `TCIM_RESP_OKAY :
                `TCIM_RESP_SLVERR;
        end
        else if (bValid_q && s_axi_bready)
        begin
            bValid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 8'h00;
            wLane0_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= `TCIM_RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wLane0_q <= wLane0_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            s_axi_awready <= !awHeld_d && !s_axi_awready;
            s_axi_wready <= !wHeld_d && !s_axi_wready;
        end
    end

    // Only byte lane 0 carries meaningful bits; upper bits ignored
    always_comb
    begin
        enStrobe = 8'h00;
        disStrobe = 8'h00;
        if (doWrite && wLane0_q)
        begin
            if (awAddr_q == `TCIM_OFS_ENABLE)
                enStrobe = wData_q;
            if (awAddr_q == `TCIM_OFS_DISABLE)
            begin
                disStrobe = wData_q;
                // Compare A/B disables ignored outside waveform mode
                disStrobe[`TCIM_BIT_CMPA] = wData_q[`TCIM_BIT_CMPA] &
                    waveMode;
                disStrobe[`TCIM_BIT_CMPB] = wData_q[`TCIM_BIT_CMPB] &
                    waveMode;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++)
        begin : g_src
            tcim_mask_bit u_mask
            (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .enPulse(enStrobe[gi]),
                .disPulse(disStrobe[gi]),
                .mask_q(maskBits[gi])
            );
            tcim_flag_bit u_flag
            (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .setPulse(events[gi]),
                .clrPulse(statusRead),
                .flag_q(flagBits[gi])
            );
        end
    endgenerate

    // One read at a time; arready is a single-cycle pulse
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign statusRead = arTake && (s_axi_araddr == `TCIM_OFS_STATUS);

    always_comb
    begin
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (arTake)
        begin
            rValid_d = 1'b1;
            rResp_d = `TCIM_RESP_OKAY;
            unique case (s_axi_araddr)
                `TCIM_OFS_MASK:
                    rData_d = {24'h000000, maskBits};
                `TCIM_OFS_STATUS: rData_d = {24'h000000, flagBits};
                `TCIM_OFS_ENABLE, `TCIM_OFS_DISABLE: rData_d = 32'h00000000;
                default:
                begin
                    rData_d = 32'h00000000;
                    rResp_d = `TCIM_RESP_SLVERR;
                end
            endcase
        end
        else if (rValid_q && s_axi_rready)
        begin
            rValid_d = 1'b0;
        end
        irq_d = |(flagBits & maskBits);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= `TCIM_RESP_OKAY;
            s_axi_arready <= 1'b0;
            chanIrq_q <= 1'b0;
        end
        else
        begin
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
            s_axi_arready <= !rValid_d && !s_axi_arready && !arTake;
            chanIrq_q <= irq_d;
        end
    end

    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    sequence s_dis_write(int b);
        doWrite && wLane0_q && awAddr_q == `TCIM_OFS_DISABLE && wData_q[b];
    endsequence

    a_dis_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_dis_write(`TCIM_BIT_CMPC) |=> !maskBits[`TCIM_BIT_CMPC])
        else $error("disable did not clear mask");
    a_en_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
        enStrobe[`TCIM_BIT_OVF] |=> maskBits[`TCIM_BIT_OVF])
        else $error("enable did not set mask");
    a_cmpa_guard: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_dis_write(`TCIM_BIT_CMPA) ##0
        (!waveMode && maskBits[`TCIM_BIT_CMPA] && !enStrobe[`TCIM_BIT_CMPA])
        |=> maskBits[`TCIM_BIT_CMPA])
        else $error("compare A disabled outside wave mode");
    a_mask_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        arTake && s_axi_araddr == `TCIM_OFS_MASK |=>
        rData_q == {24'h000000, $past(maskBits)})
        else $error("mask read mismatch");
    a_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper bits not zero");
    a_status_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        statusRead && !events[`TCIM_BIT_LDA] |=>
        !flagBits[`TCIM_BIT_LDA])
        else $error("status read did not clear");
    a_irq_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
        |(flagBits & maskBits) |=> chanIrq_q)
        else $error("irq missing");
    a_irq_drops: assert property (@(posedge clk_sys) disable iff (!resetn)
        (flagBits & maskBits) == 8'h00 |=> !chanIrq_q)
        else $error("irq stuck");
    a_bit_map: assert property (@(posedge clk_sys) disable iff (!resetn)
        evtExtTrigger |=> flagBits[7] ##1 1'b1)
        else $error("trigger flag bit wrong");
endmodule

// ===== bench/tcim_axi_master.sv
/*
 AXI4-Lite master standing in for processor software.
 Assumes one clock; signals change only after rising edges.
*/
`timescale 1ns/1ps
module tcim_axi_master
(
    input wire logic clk_sys,
    output logic [3:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [3:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    logic tmo = 1'b0;
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Released payload is inverted so stale values never pass
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        logic pa;
        logic pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while ((pa || pw) && n < 100)
        begin
            @(posedge clk_sys);
            n++;
            if (pa && awready === 1'b1)
            begin
                pa = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (pw && wready === 1'b1)
            begin
                pw = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        // Slow answer taken at random
        repeat ($urandom_range(2)) @(posedge clk_sys);
        bready <= 1'b1;
        @(posedge clk_sys);
        while (bvalid !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
        r = bresp;
        bready <= 1'b0;
        tmo = n >= 200;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clk_sys);
        while (arready !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat ($urandom_range(2)) @(posedge clk_sys);
        rready <= 1'b1;
        @(posedge clk_sys);
        while (rvalid !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        tmo = n >= 200;
    endtask
endmodule

// ===== bench/timer_channel_irq_mask_bench.sv
/*
 Self-checking bench of the interrupt mask block against an integer model.
 Assumes the bus master partner and the design files are compiled first.
*/
`timescale 1ns/1ps
module timer_channel_irq_mask_bench;
    import tcim_pkg::*;
    logic clk_sys, resetn, waveMode, chanIrq_q;
    tcim_src_t evt;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, wm, op;
    int fail_count = 0;
    int check_count = 0;
    int mask, flags, ev;
    tcim_axi_master m (.clk_sys, .awaddr, .awvalid, .awready, .wdata,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    tcim_top dut (.clk_sys, .resetn, .waveMode, .evtOverflow(evt[0]),
        .evtLoadOverrun(evt[1]), .evtCompareA(evt[2]),
        .evtCompareB(evt[3]), .evtCompareC(evt[4]), .evtCaptureA(evt[5]),
        .evtCaptureB(evt[6]), .evtExtTrigger(evt[7]),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chanIrq_q);
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang();
        if (m.tmo)
        begin
            fail_count++;
            $display("[ERR] bus answer expected in time seen timeout");
            wrap_up();
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] v,
        input logic [1:0] er);
        logic [1:0] r;
        m.wr(a, v, r);
        hang();
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rchk(input logic [3:0] a, input int exp,
        input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] r;
        m.rd(a, v, r);
        hang();
        chk("rresp", {30'h0, er}, {30'h0, r});
        if (er == 2'h0)
            chk("rdata", exp, v);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        resetn = 1'b0;
        waveMode = 1'b0;
        evt = 8'h00;
        void'($urandom(32'h419eb90b));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        mask = 0;
        flags = 0;
        rchk(4'h8, 0, 2'h0);
        wreg(4'h0, 32'hffff_ff5a, 2'h0);
        mask = 'h5a;
        rchk(4'h8, mask, 2'h0);
        wreg(4'h8, 32'h0, 2'h2);
        wreg(4'h2, 32'hff, 2'h2);
        rchk(4'h2, 0, 2'h2);
        rchk(4'h4, 0, 2'h0);
        rchk(4'h8, mask, 2'h0);
        for (int w = 0; w < 2; w++)
            for (int i = 0; i < 8; i++)
            begin
                waveMode <= w[0];
                wreg(4'h0, 32'hff, 2'h0);
                mask = 'hff;
                wreg(4'h4, 32'h1 << i, 2'h0);
                if (w == 1 || (i != 2 && i != 3))
                    mask &= ~(1 << i);
                rchk(4'h8, mask, 2'h0);
            end
        // Random mask updates mixed with events and status reads
        for (int k = 0; k < 40; k++)
        begin
            d = $urandom;
            wm = $urandom_range(1);
            op = $urandom_range(1);
            waveMode <= wm;
            wreg(op ? 4'h4 : 4'h0, d, 2'h0);
            if (op)
                mask &= ~(d[7:0] & (wm ? 8'hff : 8'hf3));
            else
                mask |= d[7:0];
            rchk(4'h8, mask, 2'h0);
            ev = $urandom_range(255);
            evt <= ev[7:0];
            @(posedge clk_sys);
            evt <= 8'h00;
            flags |= ev;
            repeat (3) @(posedge clk_sys);
            chk("irq", (flags & mask) != 0, chanIrq_q);
            if (k[0])
            begin
                rchk(4'hc, flags, 2'h0);
                flags = 0;
                repeat (3) @(posedge clk_sys);
                chk("irq", 0, chanIrq_q);
            end
        end
        wrap_up();
    end
endmodule
